// file: pkg/sbx_pkg.sv
// package: opcodes, field layouts and constants for the saturate/bitfield/extend unit
// Contract
// [RULE_01] signed clamp bit position 1..32 only
// [RULE_02] unsigned clamp bit position 0..31 only
// [RULE_03] optional pre-shift: arithmetic right or logical left
// [RULE_04] signed clamp: shift, then limit to n-bit range
// [RULE_05] unsigned clamp: negative to zero, cap 2^n-1
// [RULE_06] clamp changed value sets sticky saturation flag
// [RULE_07] only status write clears saturation flag
// [RULE_08] saturation flag readable by status read
// [RULE_09] clamps leave condition flags unchanged
// [RULE_10] field clear zeroes width bits from lsb
// [RULE_11] field insert copies source low bits into field
// [RULE_12] issuer keeps lsb 0..31, width 1..32-lsb
// [RULE_13] signed field extract sign-extends field to 32
// [RULE_14] unsigned field extract zero-extends field to 32
// [RULE_15] extends rotate source right 0/8/16/24 first
// [RULE_16] byte extends use bits 7..0
// [RULE_17] halfword extends use bits 15..0
// [RULE_18] field and extend ops leave flags unchanged
// [RULE_19] no stack pointer or program counter for clamps
// [RULE_20] no stack pointer or program counter for field ops
// [RULE_21] failed condition suppresses write and flag update
package sbx_pkg;

   // ----------------------------------------
   // widths
   // ----------------------------------------
   localparam int SBX_DATA_W = 32;
   localparam int SBX_POS_W = 5;
   localparam int SBX_WID_W = 6;
   localparam logic [5:0] SBX_WORD_BITS = 6'h20;
   localparam logic [31:0] SBX_ZERO_WORD = 32'h0000_0000;
   localparam logic [31:0] SBX_ONES_WORD = 32'hffff_ffff;
   localparam logic [3:0] SBX_NZCV_RESET = 4'h0;
   localparam logic SBX_SAT_RESET = 1'b0;

   // ----------------------------------------
   // extend fields
   // ----------------------------------------
   localparam int SBX_BYTE_TOP = 7;
   localparam int SBX_HALF_TOP = 15;
   localparam int SBX_ROT_UNIT = 8;

   // ----------------------------------------
   // operation and shift encodings
   // ----------------------------------------
   typedef enum logic [3:0] {
      SBX_OP_NONE = 4'h0,
      SBX_OP_SIGNED_CLAMP = 4'h1,
      SBX_OP_UNSIGNED_CLAMP = 4'h2,
      SBX_OP_FIELD_CLEAR = 4'h3,
      SBX_OP_FIELD_INSERT = 4'h4,
      SBX_OP_SIGNED_FIELD_EXTRACT = 4'h5,
      SBX_OP_UNSIGNED_FIELD_EXTRACT = 4'h6,
      SBX_OP_SIGN_EXTEND_BYTE = 4'h7,
      SBX_OP_SIGN_EXTEND_HALF = 4'h8,
      SBX_OP_ZERO_EXTEND_BYTE = 4'h9,
      SBX_OP_ZERO_EXTEND_HALF = 4'ha
   } sbx_op_t;

   typedef enum logic {
      SBX_SHIFT_LEFT = 1'b0,
      SBX_SHIFT_RIGHT_ARITH = 1'b1
   } sbx_shift_t;

   // ----------------------------------------
   // carriers
   // ----------------------------------------
   typedef struct packed {
      logic valid;
      logic cond_pass;
      sbx_op_t op;
      logic [31:0] source_operand;
      logic [31:0] field_source;
      logic [31:0] dest_old;
      logic [5:0] clamp_pos;
      sbx_shift_t shift_kind;
      logic [4:0] shift_amount;
      logic [4:0] field_lsb;
      logic [5:0] field_width;
      logic [1:0] rotate_right_amount;
   } sbx_req_t;

   typedef struct packed {
      logic wr_en;
      logic [31:0] data;
   } sbx_result_t;

endpackage : sbx_pkg

// file: design/sbx_unit.sv
// saturate, bitfield and extend datapath unit with sticky saturation flag
module sbx_unit
(
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_reset_n,
   // issued operation
   input wire sbx_pkg::sbx_req_t i_req,
   // status word access
   input wire logic i_status_wr,
   input wire logic i_status_wr_sat,
   input wire logic [3:0] i_status_wr_nzcv,
   // destination write
   output sbx_pkg::sbx_result_t o_result,
   // status word view
   output logic o_sat_flag,
   output logic [3:0] o_nzcv
);
   import sbx_pkg::*;

   // ----------------------------------------
   // pre-shift
   // ----------------------------------------
   logic [31:0] shifted;
   always_comb
   begin
      if (i_req.shift_kind == SBX_SHIFT_RIGHT_ARITH)
      begin
         shifted = $unsigned($signed(i_req.source_operand) >>> i_req.shift_amount); // [RULE_03]
      end
      else
      begin
         shifted = i_req.source_operand << i_req.shift_amount; // [RULE_03]
      end
   end

   // ----------------------------------------
   // clamps
   // ----------------------------------------
   // bound widths are 64-bit so n=32 does not overflow the limit math
   logic [63:0] sx;
   logic signed [63:0] s_max;
   logic signed [63:0] s_min;
   logic signed [63:0] u_max;
   logic [31:0] clamp_val;
   logic clamp_hit;
   logic [5:0] pos_m1;
   always_comb
   begin
      sx = {{32{shifted[31]}}, shifted};
      pos_m1 = i_req.clamp_pos - 6'h01;
      s_max = (64'sh1 <<< pos_m1) - 64'sh1;
      s_min = -(64'sh1 <<< pos_m1);
      u_max = (64'sh1 <<< i_req.clamp_pos) - 64'sh1;
      clamp_val = shifted;
      clamp_hit = 1'b0;
      if (i_req.op == SBX_OP_SIGNED_CLAMP)
      begin
         // position held to 1..32 by the issuer
         if ($signed(sx) > s_max) // [RULE_01] [RULE_04]
         begin
            clamp_val = s_max[31:0];
            clamp_hit = 1'b1;
         end
         else if ($signed(sx) < s_min) // [RULE_04]
         begin
            clamp_val = s_min[31:0];
            clamp_hit = 1'b1;
         end
      end
      else if (i_req.op == SBX_OP_UNSIGNED_CLAMP)
      begin
         if (shifted[31]) // [RULE_05]
         begin
            clamp_val = SBX_ZERO_WORD;
            clamp_hit = 1'b1;
         end
         else if ($signed(sx) > u_max) // [RULE_02] [RULE_05]
         begin
            clamp_val = u_max[31:0];
            clamp_hit = 1'b1;
         end
      end
   end

   // ----------------------------------------
   // field mask
   // ----------------------------------------
   // width 32 would overflow a 32-bit shift, so build from a 64-bit one
   logic [63:0] wide_mask;
   logic [31:0] low_mask;
   logic [31:0] field_mask;
   logic [31:0] extracted;
   logic [5:0] top_pos;
   logic [31:0] sext_extract;
   always_comb
   begin
      wide_mask = (64'h1 << i_req.field_width) - 64'h1;
      low_mask = wide_mask[31:0];
      field_mask = low_mask << i_req.field_lsb; // [RULE_12]
      extracted = (i_req.field_source >> i_req.field_lsb) & low_mask;
      top_pos = i_req.field_width - 6'h01;
      if (extracted[top_pos[4:0]]) // [RULE_13]
      begin
         sext_extract = extracted | ~low_mask;
      end
      else
      begin
         sext_extract = extracted;
      end
   end

   // ----------------------------------------
   // rotate for extends
   // ----------------------------------------
   logic [63:0] rot_dbl;
   logic [31:0] rotated;
   logic [5:0] rot_bits;
   always_comb
   begin
      rot_bits = 6'(i_req.rotate_right_amount * SBX_ROT_UNIT);
      rot_dbl = {i_req.source_operand, i_req.source_operand} >> rot_bits; // [RULE_15]
      rotated = rot_dbl[31:0];
   end

   // ----------------------------------------
   // result select
   // ----------------------------------------
   logic [31:0] res_next;
   logic known_op;
   always_comb
   begin
      res_next = SBX_ZERO_WORD;
      known_op = 1'b1;
      case (i_req.op)
         SBX_OP_SIGNED_CLAMP, SBX_OP_UNSIGNED_CLAMP:
         begin
            res_next = clamp_val;
         end
         SBX_OP_FIELD_CLEAR:
         begin
            res_next = i_req.dest_old & ~field_mask; // [RULE_10]
         end
         SBX_OP_FIELD_INSERT:
         begin
            res_next = (i_req.dest_old & ~field_mask)
                     | ((i_req.field_source << i_req.field_lsb) & field_mask); // [RULE_11]
         end
         SBX_OP_SIGNED_FIELD_EXTRACT:
         begin
            res_next = sext_extract; // [RULE_13]
         end
         SBX_OP_UNSIGNED_FIELD_EXTRACT:
         begin
            res_next = extracted; // [RULE_14]
         end
         SBX_OP_SIGN_EXTEND_BYTE:
         begin
            res_next = {{24{rotated[SBX_BYTE_TOP]}}, rotated[SBX_BYTE_TOP:0]}; // [RULE_16]
         end
         SBX_OP_ZERO_EXTEND_BYTE:
         begin
            res_next = {24'h00_0000, rotated[SBX_BYTE_TOP:0]}; // [RULE_16]
         end
         SBX_OP_SIGN_EXTEND_HALF:
         begin
            res_next = {{16{rotated[SBX_HALF_TOP]}}, rotated[SBX_HALF_TOP:0]}; // [RULE_17]
         end
         SBX_OP_ZERO_EXTEND_HALF:
         begin
            res_next = {16'h0000, rotated[SBX_HALF_TOP:0]}; // [RULE_17]
         end
         default:
         begin
            known_op = 1'b0;
         end
      endcase
   end

   logic issue;
   assign issue = i_req.valid && i_req.cond_pass && known_op; // [RULE_21]

   // ----------------------------------------
   // result register
   // ----------------------------------------
   sbx_result_t result_reg;
   always_ff @(posedge i_clk_sys or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         result_reg <= '0;
      end
      else
      begin
         result_reg.wr_en <= issue; // [RULE_21]
         if (issue)
         begin
            result_reg.data <= res_next;
         end
      end
   end
   assign o_result = result_reg;

   // ----------------------------------------
   // status word
   // ----------------------------------------
   // set beats a same-cycle status write so no saturation event is lost
   logic sat_reg;
   logic sat_set;
   assign sat_set = issue && clamp_hit; // [RULE_06] [RULE_21]
   always_ff @(posedge i_clk_sys or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         sat_reg <= SBX_SAT_RESET;
      end
      else if (sat_set)
      begin
         sat_reg <= 1'b1; // [RULE_06]
      end
      else if (i_status_wr)
      begin
         sat_reg <= i_status_wr_sat; // [RULE_07]
      end
   end
   assign o_sat_flag = sat_reg; // [RULE_08]

   // only status writes touch these; no op of this unit does
   logic [3:0] nzcv_reg;
   always_ff @(posedge i_clk_sys or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         nzcv_reg <= SBX_NZCV_RESET;
      end
      else if (i_status_wr)
      begin
         nzcv_reg <= i_status_wr_nzcv; // [RULE_09] [RULE_18]
      end
   end
   assign o_nzcv = nzcv_reg;

endmodule : sbx_unit

// file: bench/sbx_unit_assertions.sv
// assertion checker for the saturate/bitfield/extend unit
module sbx_unit_assertions
(
   input wire logic i_clk_sys,
   input wire logic i_reset_n,
   input wire sbx_pkg::sbx_req_t i_req,
   input wire logic i_status_wr,
   input wire logic i_status_wr_sat,
   input wire logic [3:0] i_status_wr_nzcv,
   input wire sbx_pkg::sbx_result_t o_result,
   input wire logic o_sat_flag,
   input wire logic [3:0] o_nzcv
);
   import sbx_pkg::*;
   default clocking @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_reset_n);
   wire tk = i_req.valid && i_req.cond_pass;
   wire clamp = tk && (i_req.op inside {SBX_OP_SIGNED_CLAMP, SBX_OP_UNSIGNED_CLAMP});
   AST_TAKEN: assert property (tk && i_req.op inside {[1:10]} |=> o_result.wr_en) else $error("no write");
   AST_SUPPRESS: assert property (!tk |=> !o_result.wr_en) else $error("write leak");
   AST_STICKY: assert property ($fell(o_sat_flag) |-> $past(i_status_wr)) else $error("flag cleared");
   AST_SET: assert property ($rose(o_sat_flag) |-> $past(clamp || i_status_wr)) else $error("flag set");
   AST_NZCV: assert property ($changed(o_nzcv) |-> $past(i_status_wr)) else $error("nzcv moved");
   AST_READ: assert property (i_status_wr && !clamp |=> o_sat_flag == $past(i_status_wr_sat)
      && o_nzcv == $past(i_status_wr_nzcv)) else $error("status load");
   AST_UNSIGNED_CLAMP: assert property (tk && i_req.op == SBX_OP_UNSIGNED_CLAMP |=> !o_result.data[31])
      else $error("unsigned_clamp sign");
   AST_ZXB: assert property (tk && i_req.op == SBX_OP_ZERO_EXTEND_BYTE |=> o_result.data[31:8] == 24'h0)
      else $error("zxb");
   AST_ZXH: assert property (tk && i_req.op == SBX_OP_ZERO_EXTEND_HALF |=> o_result.data[31:16] == 16'h0)
      else $error("zxh");
   cover property (clamp ##1 $rose(o_sat_flag));
   cover property (i_status_wr ##1 !o_sat_flag);
   cover property (tk && i_req.op == SBX_OP_FIELD_INSERT);
endmodule : sbx_unit_assertions

bind sbx_unit sbx_unit_assertions i_sbx_unit_assertions (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
   .i_req(i_req), .i_status_wr(i_status_wr), .i_status_wr_sat(i_status_wr_sat),
   .i_status_wr_nzcv(i_status_wr_nzcv), .o_result(o_result), .o_sat_flag(o_sat_flag), .o_nzcv(o_nzcv));

// file: bench/sbx_core_model.sv
// register file side: counts destination writes
module sbx_core_model
(
   input wire logic i_clk_sys,
   input wire logic i_reset_n,
   input wire sbx_pkg::sbx_result_t i_result,
   output logic [7:0] o_wr_cnt
);
   timeunit 1ns;
   timeprecision 1ps;
   always_ff @(posedge i_clk_sys or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         o_wr_cnt <= 8'h00;
      end
      else if (i_result.wr_en)
      begin
         o_wr_cnt <= o_wr_cnt + 8'h01;
      end
   end
endmodule : sbx_core_model

// file: bench/sbx_unit_tb.sv
// self-checking bench for the saturate/bitfield/extend unit
module sbx_unit_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import sbx_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   sbx_req_t req = '0;
   logic swr = 1'b0;
   logic swr_sat = 1'b0;
   logic [3:0] swr_nzcv = 4'h0;
   sbx_result_t res;
   logic sat;
   logic [3:0] nzcv;
   logic [7:0] wr_cnt;
   int bad_count = 0;
   int n_checks = 0;
   int cyc = 0;
   initial
   begin
      forever #5 clk = ~clk;
   end
   // hang guard: whole run needs well under 100 cycles
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 2000)
      begin
         bad_count++;
         summarize();
      end
   end
   sbx_unit i_sbx_unit (.i_clk_sys(clk), .i_reset_n(rst_n), .i_req(req), .i_status_wr(swr),
      .i_status_wr_sat(swr_sat), .i_status_wr_nzcv(swr_nzcv), .o_result(res), .o_sat_flag(sat), .o_nzcv(nzcv));
   sbx_core_model i_sbx_core_model (.i_clk_sys(clk), .i_reset_n(rst_n), .i_result(res), .o_wr_cnt(wr_cnt));
   task automatic chk(logic [31:0] got, logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // operands are plain values, never stack pointer or program counter
   task automatic run(logic [31:0] exp);
      req.valid = 1'b1;
      @(negedge clk);
      chk(res.wr_en, 1'b1);
      chk(res.data, exp);
   endtask : run
   task automatic t_clamp();
      req.cond_pass = 1'b1;
      req.op = SBX_OP_SIGNED_CLAMP;
      req.source_operand = 32'h0000_0100;
      req.clamp_pos = 6'h08;
      run(32'h0000_007f);
      chk(sat, 1'b1);
      req.shift_kind = SBX_SHIFT_RIGHT_ARITH;
      req.shift_amount = 5'h04;
      req.source_operand = 32'hffff_f000;
      run(32'hffff_ff80);
      req.shift_kind = SBX_SHIFT_LEFT;
      req.shift_amount = 5'h00;
      req.source_operand = 32'h8000_0000;
      req.clamp_pos = 6'h20;
      run(32'h8000_0000);
      req.op = SBX_OP_UNSIGNED_CLAMP;
      req.clamp_pos = 6'h1f;
      run(32'h0000_0000);
      req.shift_amount = 5'h04;
      req.source_operand = 32'h0000_1234;
      req.clamp_pos = 6'h10;
      run(32'h0000_ffff);
      req.clamp_pos = 6'h00;
      run(32'h0000_0000);
      $display("test clamp done");
   endtask : t_clamp
   task automatic t_status();
      chk(nzcv, 4'h0);
      req.valid = 1'b0;
      swr = 1'b1;
      swr_nzcv = 4'ha;
      @(negedge clk);
      swr = 1'b0;
      chk(sat, 1'b0);
      chk(nzcv, 4'ha);
      req.cond_pass = 1'b0;
      req.op = SBX_OP_SIGNED_CLAMP;
      req.shift_amount = 5'h00;
      req.clamp_pos = 6'h08;
      req.source_operand = 32'hffff_0000;
      req.valid = 1'b1;
      @(negedge clk);
      chk(res.wr_en, 1'b0);
      chk(sat, 1'b0);
      req.cond_pass = 1'b1;
      req.source_operand = 32'h0000_0010;
      run(32'h0000_0010);
      chk(sat, 1'b0);
      $display("test status done");
   endtask : t_status
   task automatic t_field();
      req.op = SBX_OP_FIELD_CLEAR;
      req.dest_old = 32'hffff_ffff;
      req.field_lsb = 5'h08;
      req.field_width = 6'h0c;
      run(32'hfff0_00ff);
      req.op = SBX_OP_FIELD_INSERT;
      req.field_source = 32'h1234_5abc;
      run(32'hfffa_bcff);
      req.field_lsb = 5'h1f;
      req.field_width = 6'h01;
      run(32'h7fff_ffff);
      req.op = SBX_OP_SIGNED_FIELD_EXTRACT;
      req.field_source = 32'h0080_0000;
      req.field_lsb = 5'h14;
      req.field_width = 6'h04;
      run(32'hffff_fff8);
      req.op = SBX_OP_UNSIGNED_FIELD_EXTRACT;
      run(32'h0000_0008);
      chk({sat, nzcv}, 5'h0a);
      $display("test field done");
   endtask : t_field
   task automatic t_ext();
      logic [31:0] r;
      req.source_operand = 32'h80f7_1234;
      for (int i = 0; i < 16; i++)
      begin
         req.op = sbx_op_t'(4'h7 + {2'h0, i[3:2]});
         req.rotate_right_amount = i[1:0];
         r = 32'({req.source_operand, req.source_operand} >> (8 * i[1:0]));
         case (i[3:2])
            2'h0: r = {{24{r[7]}}, r[7:0]};
            2'h1: r = {{16{r[15]}}, r[15:0]};
            2'h2: r = {24'h0, r[7:0]};
            default: r = {16'h0, r[15:0]};
         endcase
         run(r);
      end
      req.valid = 1'b0;
      @(negedge clk);
      chk({sat, nzcv, wr_cnt}, 13'h0a1c);
      $display("test extend done");
   endtask : t_ext
   // saturation and status write in one cycle: the set must win
   task automatic t_sticky();
      req.op = SBX_OP_SIGNED_CLAMP;
      req.cond_pass = 1'b1;
      req.shift_kind = SBX_SHIFT_LEFT;
      req.shift_amount = 5'h00;
      req.clamp_pos = 6'h08;
      req.source_operand = 32'h0000_0200;
      swr = 1'b1;
      swr_sat = 1'b0;
      swr_nzcv = 4'h5;
      run(32'h0000_007f);
      chk(sat, 1'b1);
      chk(nzcv, 4'h5);
      req.valid = 1'b0;
      swr_sat = 1'b1;
      @(negedge clk);
      chk(sat, 1'b1);
      swr_sat = 1'b0;
      @(negedge clk);
      swr = 1'b0;
      chk(sat, 1'b0);
      $display("test sticky done");
   endtask : t_sticky
   task automatic summarize();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
      begin
         $display("ALL TESTS PASSED");
      end
      else
      begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : summarize
   initial
   begin
      repeat (5) @(negedge clk);
      rst_n = 1'b1;
      t_clamp();
      t_status();
      t_field();
      t_ext();
      t_sticky();
      summarize();
   end
endmodule : sbx_unit_tb
